// >>> hw/mtsir_pkg.sv
//
// Overview of operation
// - A 12-bit down counter is decremented once every 4 us by a prescaler.
// - The counter loads from both reload registers; counting starts on timer start.
// - On borrow, raise the timer interrupt, reload the counter, keep counting.
// - Each timer start restarts counting; new reload contents change the timeout.
// - The timer flip-flop is set by timer start, cleared on borrow, drives the pin.
// - The timer interrupt can be masked.
// - The serial clock source is internal at 1 Mbit/s or external up to 1 Mbit/s.
// - Serial clock and shifting run only while serial select is held low.
// - Serial data shifts most significant bit first.
// - Ack rises on a CPU transfer, falls when the buffer fills, blocking reception.
// - Each interrupt has a fixed vector and fixed priority.
// - Six sources: three external, timer, serial, and non-maskable software.
// - Selectable-edge input uses rising edges when edge select is 1, else falling.
// - Reset clears interrupt enables, request flags and the halt flip-flop.
// - Reset sets the port B mode register to all ones, all lines input.
// - Reset sets the port C mode register to all ones and drives outputs low.
// - Reset clears all processor flags.
// - Reset sets the count to all ones, clears timer ff, sets ack, clears grant.
// - Reset floats the buses and strobes and zeroes the program counter.
// - Full-address mode gives 16 address lines; nibble mode 12 plus 4 outputs.
// - Full-output mode drives register B high and register C low on port E.
// - Port C lines 2, 3, 4 take select, ack and timer roles when mode bit is 0.
// - Serial input is sampled on rising clock edges; output changes on falling.
package mtsir_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS    = 5;
  localparam int TICK_NS   = 4000;
  localparam int TICK_CYC  = TICK_NS / CLK_NS;
  localparam int SBIT_NS   = 1000;
  localparam int SHALF_CYC = SBIT_NS / (2 * CLK_NS);

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  MODE_B_RST = 8'hff;
  localparam logic [7:0]  MODE_C_RST = 8'hff;
  localparam logic [7:0]  MASK_RST   = 8'hff;
  localparam logic [11:0] COUNT_RST  = 12'hfff;
  localparam logic [15:0] PC_RST     = 16'h0000;

  // ****************************************************************
  // Special register select codes
  // ****************************************************************
  localparam logic [3:0] SR_PB  = 4'h1;
  localparam logic [3:0] SR_PC  = 4'h2;
  localparam logic [3:0] SR_MK  = 4'h3;
  localparam logic [3:0] SR_MB  = 4'h4;
  localparam logic [3:0] SR_MC  = 4'h5;
  localparam logic [3:0] SR_TM0 = 4'h6;
  localparam logic [3:0] SR_TM1 = 4'h7;
  localparam logic [3:0] SR_S   = 4'h8;
  localparam logic [3:0] SR_PEN = 4'h9;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MK_LEVEL = 0;
  localparam int MK_RISE  = 1;
  localparam int MK_SEL   = 2;
  localparam int MK_TIMER = 3;
  localparam int MK_SER   = 4;
  localparam int MK_ES    = 5;
  localparam int PC_SCS   = 2;
  localparam int PC_ACK   = 3;
  localparam int PC_TMR   = 4;
  localparam int PC_HGR   = 6;
  localparam int PC_HREQ  = 7;
  // Request index order equals priority order, highest first
  localparam int SRC_SOFT  = 0;
  localparam int SRC_LEVEL = 1;
  localparam int SRC_TIMER = 2;
  localparam int SRC_RISE  = 3;
  localparam int SRC_SEL   = 4;
  localparam int SRC_SER   = 5;
  localparam int SY_SCK    = 0;
  localparam int SY_SI     = 1;
  localparam int SY_SCS    = 2;
  localparam int SY_HREQ   = 3;
  localparam int SY_LEVEL  = 4;
  localparam int SY_RISE   = 5;
  localparam int SY_SEL    = 6;
  localparam int SY_W      = 7;

  // ****************************************************************
  // Vectors
  // ****************************************************************
  localparam logic [7:0] VEC_SOFT  = 8'h60;
  localparam logic [7:0] VEC_LEVEL = 8'h04;
  localparam logic [7:0] VEC_TIMER = 8'h08;
  localparam logic [7:0] VEC_RISE  = 8'h10;
  localparam logic [7:0] VEC_SEL   = 8'h20;
  localparam logic [7:0] VEC_SER   = 8'h40;

  typedef enum logic [1:0] {
    PE_ADDR16 = 2'b00,
    PE_NIBBLE = 2'b01,
    PE_OUT16  = 2'b10
  } mtsir_pe_mode_t;
endpackage

// >>> hw/mtsir_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mtsir_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> hw/mtsir_core.sv
`timescale 1ns/1ps
`default_nettype none
module mtsir_core
  import mtsir_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        timer_start_instr,
  input  wire logic        full_addr_instr,
  input  wire logic        nibble_mode_instr,
  input  wire logic        full_output_mode_instr,
  input  wire logic        halt_instr,
  input  wire logic        irq_enable_instr,
  input  wire logic        irq_disable_instr,
  input  wire logic        software_irq,
  input  wire logic        irq_accept,
  input  wire logic        sr_wr,
  input  wire logic [3:0]  sr_sel,
  input  wire logic [7:0]  sr_wdata,
  input  wire logic        ser_rd,
  input  wire logic        serial_clk_int,
  input  wire logic        flags_wr,
  input  wire logic [1:0]  flags_wdata,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_wdata,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  reg_b,
  input  wire logic [7:0]  reg_c,
  input  wire logic        sck_in,
  input  wire logic        si,
  input  wire logic        serial_select_n,
  input  wire logic        hold_req,
  input  wire logic        ext_level_irq,
  input  wire logic        ext_rise_irq,
  input  wire logic        ext_select_edge_irq,
  output logic             sck_out,
  output logic             sck_oe,
  output logic             so,
  output logic [7:0]       ser_data,
  output logic             serial_ack,
  output logic             timer_out_pin,
  output logic [11:0]      timer_count,
  output logic [7:0]       pc_out,
  output logic [7:0]       pc_oe,
  output logic [7:0]       pb_out,
  output logic [7:0]       pb_oe,
  output logic [15:0]      pe_out,
  output logic             pe_oe,
  output logic             bus_oe,
  output logic             irq_req,
  output logic [7:0]       irq_vector,
  output logic             halted,
  output logic             hold_grant,
  output logic [1:0]       proc_flags,
  output logic [15:0]      prog_counter
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [2:0] first_set(input logic [5:0] r);
    logic [2:0] idx;
    idx = 3'd0;
    for (int i = 5; i >= 0; i--) begin
      if (r[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [7:0] vec_of(input logic [2:0] idx);
    logic [7:0] v;
    case (idx)
      3'd0:    v = VEC_SOFT;
      3'd1:    v = VEC_LEVEL;
      3'd2:    v = VEC_TIMER;
      3'd3:    v = VEC_RISE;
      3'd4:    v = VEC_SEL;
      default: v = VEC_SER;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SY_W-1:0] sy;
  logic            sck_d;
  logic            rise_d;
  logic            sel_d;

  mtsir_sync #(.W(SY_W)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({ext_select_edge_irq, ext_rise_irq, ext_level_irq,
                hold_req, serial_select_n, si, sck_in}),
    .q       (sy)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_d  <= 1'b1;
      rise_d <= 1'b0;
      sel_d  <= 1'b0;
    end else begin
      sck_d  <= sy[SY_SCK];
      rise_d <= sy[SY_RISE];
      sel_d  <= sy[SY_SEL];
    end
  end

  // ****************************************************************
  // Special registers
  // ****************************************************************
  logic [7:0]     mode_b;
  logic [7:0]     mode_c;
  logic [7:0]     mask;
  logic [7:0]     pb_latch;
  logic [7:0]     pc_latch;
  logic [7:0]     reload_low;
  logic [3:0]     reload_high;
  logic [3:0]     pe_nib;
  mtsir_pe_mode_t pe_mode;

  wire wr_pb  = sr_wr & (sr_sel == SR_PB);
  wire wr_pc  = sr_wr & (sr_sel == SR_PC);
  wire wr_mk  = sr_wr & (sr_sel == SR_MK);
  wire wr_mb  = sr_wr & (sr_sel == SR_MB);
  wire wr_mc  = sr_wr & (sr_sel == SR_MC);
  wire wr_tm0 = sr_wr & (sr_sel == SR_TM0);
  wire wr_tm1 = sr_wr & (sr_sel == SR_TM1);
  wire wr_s   = sr_wr & (sr_sel == SR_S);
  wire wr_pen = sr_wr & (sr_sel == SR_PEN);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_b      <= MODE_B_RST;
      mode_c      <= MODE_C_RST;
      mask        <= MASK_RST;
      pb_latch    <= '0;
      pc_latch    <= '0;
      reload_low  <= '0;
      reload_high <= '0;
      pe_nib      <= '0;
    end else begin
      if (wr_pb)  pb_latch    <= sr_wdata;
      if (wr_pc)  pc_latch    <= sr_wdata;
      if (wr_mk)  mask        <= sr_wdata;
      if (wr_mb)  mode_b      <= sr_wdata;
      if (wr_mc)  mode_c      <= sr_wdata;
      if (wr_tm0) reload_low  <= sr_wdata;
      if (wr_tm1) reload_high <= sr_wdata[3:0];
      if (wr_pen) pe_nib      <= sr_wdata[3:0];
    end
  end

  // ****************************************************************
  // Interval timer
  // ****************************************************************
  logic [9:0] presc;
  logic       running;
  logic       timer_ff;

  wire [11:0] reload = {reload_high, reload_low};
  wire        tick   = running & (presc == 10'(TICK_CYC - 1));
  wire        borrow = tick & (timer_count == '0);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc   <= '0;
      running <= 1'b0;
    end else if (timer_start_instr) begin
      presc   <= '0;
      running <= 1'b1;
    end else if (running) begin
      presc   <= tick ? '0 : presc + 10'd1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_count <= COUNT_RST;
      timer_ff    <= 1'b0;
    end else if (timer_start_instr) begin
      timer_count <= reload;
      timer_ff    <= 1'b1;
    end else if (borrow) begin
      timer_count <= reload;
      timer_ff    <= 1'b0;
    end else if (tick) begin
      timer_count <= timer_count - 12'd1;
    end
  end

  // ****************************************************************
  // Serial port
  // ****************************************************************
  logic [7:0] sdiv;
  logic [2:0] bitcnt;

  wire ser_en   = ~mode_c[PC_SCS] & ~sy[SY_SCS];
  wire int_run  = ser_en & serial_clk_int & serial_ack;
  wire int_wrap = int_run & (sdiv == 8'(SHALF_CYC - 1));
  wire ext_rise = sy[SY_SCK] & ~sck_d;
  wire ext_fall = ~sy[SY_SCK] & sck_d;
  wire shift_ok = ser_en & serial_ack;
  wire sck_rise = shift_ok & (serial_clk_int ? int_wrap & ~sck_out : ext_rise);
  wire sck_fall = shift_ok & (serial_clk_int ? int_wrap & sck_out : ext_fall);
  wire ser_full = sck_rise & (bitcnt == 3'd7);

  // Internal clock idles high and only runs while a byte can be taken
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdiv    <= '0;
      sck_out <= 1'b1;
      sck_oe  <= 1'b0;
    end else begin
      sck_oe <= ser_en & serial_clk_int;
      if (!int_run) begin
        sdiv    <= '0;
        sck_out <= 1'b1;
      end else if (int_wrap) begin
        sdiv    <= '0;
        sck_out <= ~sck_out;
      end else begin
        sdiv    <= sdiv + 8'd1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_data <= '0;
      so       <= 1'b0;
      bitcnt   <= '0;
    end else begin
      if (wr_s) begin
        ser_data <= sr_wdata;
        so       <= sr_wdata[7];
        bitcnt   <= '0;
      end else begin
        if (ser_rd) bitcnt <= '0;
        if (sck_rise) begin
          ser_data <= {ser_data[6:0], sy[SY_SI]};
          bitcnt   <= bitcnt + 3'd1;
        end
        if (sck_fall) so <= ser_data[7];
      end
    end
  end

  // A filling buffer wins over a CPU transfer in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_ack <= 1'b1;
    end else if (ser_full) begin
      serial_ack <= 1'b0;
    end else if (wr_s || ser_rd) begin
      serial_ack <= 1'b1;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [5:0] req;
  logic       irq_en;
  logic [2:0] irq_idx;

  wire       es_hit = mask[MK_ES] ? sy[SY_SEL] & ~sel_d
                                  : ~sy[SY_SEL] & sel_d;
  wire [5:0] set_v  = {ser_full, es_hit, sy[SY_RISE] & ~rise_d,
                       borrow, sy[SY_LEVEL], software_irq};
  wire [5:0] clr_v  = irq_accept ? 6'(1) << irq_idx : '0;
  wire [5:0] en_v   = {~mask[MK_SER], ~mask[MK_SEL], ~mask[MK_RISE],
                       ~mask[MK_TIMER], ~mask[MK_LEVEL], 1'b0};
  wire [5:0] live   = req & ({6{irq_en}} & en_v | 6'b000001);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req    <= '0;
      irq_en <= 1'b0;
    end else begin
      req <= (req & ~clr_v) | set_v;
      if (irq_enable_instr) irq_en <= 1'b1;
      else if (irq_disable_instr) irq_en <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_req    <= 1'b0;
      irq_idx    <= '0;
      irq_vector <= VEC_SOFT;
    end else begin
      irq_req    <= |(live & ~clr_v);
      irq_idx    <= first_set(live & ~clr_v);
      irq_vector <= vec_of(first_set(live & ~clr_v));
    end
  end

  // ****************************************************************
  // CPU state and bus control
  // ****************************************************************
  wire hreq = ~mode_c[PC_HREQ] & sy[SY_HREQ];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halted       <= 1'b0;
      hold_grant   <= 1'b0;
      proc_flags   <= '0;
      prog_counter <= PC_RST;
      bus_oe       <= 1'b0;
      pe_oe        <= 1'b0;
    end else begin
      if (halt_instr) halted <= 1'b1;
      else if (|live) halted <= 1'b0;
      hold_grant <= hreq;
      if (flags_wr) proc_flags <= flags_wdata;
      if (pc_load) prog_counter <= pc_wdata;
      bus_oe <= ~(halted | hold_grant);
      pe_oe  <= ~hold_grant;
    end
  end

  // ****************************************************************
  // Ports B, C, E
  // ****************************************************************
  logic [15:0] next_pe_out;
  logic [7:0]  next_pc_out;

  always_comb begin
    case (pe_mode)
      PE_NIBBLE: next_pe_out = {pe_nib, cpu_addr[11:0]};
      PE_OUT16:  next_pe_out = {reg_b, reg_c};
      default:   next_pe_out = cpu_addr;
    endcase
  end

  always_comb begin
    next_pc_out = pc_latch;
    if (!mode_c[PC_ACK]) next_pc_out[PC_ACK] = serial_ack;
    if (!mode_c[PC_TMR]) next_pc_out[PC_TMR] = timer_ff;
    if (!mode_c[PC_HGR]) next_pc_out[PC_HGR] = hold_grant;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pe_mode <= PE_ADDR16;
    end else if (full_addr_instr) begin
      pe_mode <= PE_ADDR16;
    end else if (nibble_mode_instr) begin
      pe_mode <= PE_NIBBLE;
    end else if (full_output_mode_instr) begin
      pe_mode <= PE_OUT16;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pe_out        <= '0;
      pc_out        <= '0;
      pc_oe         <= 8'h78;
      pb_out        <= '0;
      pb_oe         <= '0;
      timer_out_pin <= 1'b0;
    end else begin
      pe_out        <= next_pe_out;
      pc_out        <= next_pc_out;
      pc_oe         <= {4'h7, 2'b10, ~mode_c[1:0]} & 8'h7b;
      pb_out        <= pb_latch;
      pb_oe         <= ~mode_b;
      timer_out_pin <= timer_ff;
    end
  end
endmodule
`default_nettype wire

// >>> test/mtsir_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mtsir_core_asserts
  import mtsir_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        timer_start_instr,
  input wire logic        full_addr_instr,
  input wire logic        nibble_mode_instr,
  input wire logic        full_output_mode_instr,
  input wire logic        software_irq,
  input wire logic        irq_accept,
  input wire logic        sr_wr,
  input wire logic [3:0]  sr_sel,
  input wire logic        ser_rd,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0]  reg_b,
  input wire logic [7:0]  reg_c,
  input wire logic        serial_select_n,
  input wire logic        sck_out,
  input wire logic        serial_ack,
  input wire logic        timer_out_pin,
  input wire logic [15:0] pe_out,
  input wire logic        irq_req,
  input wire logic [7:0]  irq_vector
);
  // ****************************************************************
  // Port and interrupt behaviour
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_start_pin_set: assert property (timer_start_instr |-> ##2 timer_out_pin)
    else $error("timer pin not set after start");
  a_full_out_map: assert property ((full_output_mode_instr && !full_addr_instr
    && !nibble_mode_instr) ##1 !(full_addr_instr || nibble_mode_instr)
    |=> pe_out == {$past(reg_b), $past(reg_c)}) else $error("port E output map wrong");
  a_addr_follow: assert property (full_addr_instr ##1
    !(nibble_mode_instr || full_output_mode_instr) |=> pe_out == $past(cpu_addr))
    else $error("port E address wrong");
  a_nibble_addr: assert property ((nibble_mode_instr && !full_addr_instr) ##1
    !(full_addr_instr || full_output_mode_instr)
    |=> ((pe_out ^ $past(cpu_addr)) & 16'h0fff) == 16'h0000)
    else $error("port E low address wrong");
  a_soft_first: assert property ((software_irq && !irq_accept) ##1 !irq_accept
    |=> irq_req && irq_vector == 8'h60) else $error("software vector missing");
  a_accept_clears: assert property ((irq_accept && irq_req && irq_vector == 8'h60
    && !software_irq) ##1 !software_irq |=> !(irq_req && irq_vector == 8'h60))
    else $error("accepted request not cleared");
  a_ack_held: assert property (!serial_ack && !ser_rd && !(sr_wr && sr_sel == SR_S)
    |=> !serial_ack) else $error("ack rose without transfer");
  a_ack_free: assert property (ser_rd |=> serial_ack)
    else $error("ack not set by read");
  a_sck_quiet: assert property (serial_select_n [*6] |-> $stable(sck_out))
    else $error("serial clock moved while deselected");
endmodule
bind mtsir_core mtsir_core_asserts mtsir_core_asserts_inst (
  .clk, .sys_rst, .timer_start_instr, .full_addr_instr, .nibble_mode_instr,
  .full_output_mode_instr, .software_irq, .irq_accept, .sr_wr, .sr_sel, .ser_rd,
  .cpu_addr, .reg_b, .reg_c, .serial_select_n, .sck_out, .serial_ack, .timer_out_pin,
  .pe_out, .irq_req, .irq_vector
);
`default_nettype wire

// >>> test/mtsir_ser_dev.sv
`timescale 1ns/1ps
`default_nettype none
module mtsir_ser_dev (
  input  wire logic so,
  output logic      sck_in,
  output logic      si,
  output logic      serial_select_n
);
  // ****************************************************************
  // External serial master
  // ****************************************************************
  initial begin
    sck_in = 1'b1;
    si = 1'b0;
    serial_select_n = 1'b1;
  end
  // Clock stands high between frames; half sets fast or slow answers
  task automatic xfer(input logic [7:0] tx, input int half, output logic [7:0] rx);
    serial_select_n = 1'b0;
    #half;
    for (int i = 7; i >= 0; i--) begin
      sck_in = 1'b0;
      si = tx[i];
      #half;
      sck_in = 1'b1;
      rx = {rx[6:0], so};
      #half;
    end
    // Released line shows the inverse so a stale bit cannot pass
    si = ~si;
    serial_select_n = 1'b1;
  endtask
  // Internal-clock frames: the device drives the clock, so only select and data are set
  task automatic select_with(input logic sel_n, input logic d);
    serial_select_n = sel_n;
    si = d;
  endtask
endmodule
`default_nettype wire

// >>> test/test_mtsir_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_mtsir_core;
  import mtsir_pkg::*;
  logic        clk, sys_rst, sr_wr, serial_clk_int, ext_level_irq, ext_select_edge_irq;
  logic        hold_req, ext_rise_irq;
  logic [11:0] ins;
  logic [3:0]  sr_sel;
  logic [7:0]  sr_wdata, reg_b, reg_c, rx;
  logic [1:0]  flags_wdata;
  logic [15:0] pc_wdata, cpu_addr;
  wire logic   sck_in, si, serial_select_n, sck_out, sck_oe, so, serial_ack;
  wire logic   timer_out_pin, pe_oe, bus_oe, irq_req, halted, hold_grant;
  wire logic [7:0]  ser_data, pc_out, pc_oe, pb_out, pb_oe, irq_vector;
  wire logic [11:0] timer_count;
  wire logic [15:0] pe_out, prog_counter;
  wire logic [1:0]  proc_flags;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  mtsir_core mtsir_core_inst (
    .clk, .sys_rst, .timer_start_instr(ins[0]), .full_addr_instr(ins[1]),
    .nibble_mode_instr(ins[2]), .full_output_mode_instr(ins[3]), .halt_instr(ins[8]),
    .irq_enable_instr(ins[6]), .irq_disable_instr(ins[9]), .software_irq(ins[4]),
    .irq_accept(ins[5]), .sr_wr, .sr_sel, .sr_wdata, .ser_rd(ins[7]), .serial_clk_int,
    .flags_wr(ins[10]), .flags_wdata, .pc_load(ins[11]), .pc_wdata, .cpu_addr, .reg_b,
    .reg_c, .sck_in, .si, .serial_select_n, .hold_req, .ext_level_irq,
    .ext_rise_irq, .ext_select_edge_irq, .sck_out, .sck_oe, .so, .ser_data,
    .serial_ack, .timer_out_pin, .timer_count, .pc_out, .pc_oe, .pb_out, .pb_oe,
    .pe_out, .pe_oe, .bus_oe, .irq_req, .irq_vector, .halted, .hold_grant, .proc_flags,
    .prog_counter
  );
  mtsir_ser_dev mtsir_ser_dev_inst (.so, .sck_in, .si, .serial_select_n);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is near 9000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [7:0] v);
    chk({irq_req, irq_vector}, {23'h0, 1'b1, v});
  endtask
  task automatic nwait(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input int b);
    @(negedge clk);
    ins[b] = 1'b1;
    @(negedge clk);
    ins = 12'h000;
  endtask
  task automatic sr_write(input logic [3:0] s, input logic [7:0] d);
    @(negedge clk);
    sr_wr = 1'b1;
    sr_sel = s;
    sr_wdata = d;
    @(negedge clk);
    sr_wr = 1'b0;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic do_reset(input int hold);
    sys_rst = 1'b1;
    nwait(hold);
    chk(timer_count, 32'hfff);
    chk({timer_out_pin, serial_ack, hold_grant}, 32'h2);
    chk({irq_req, halted}, 32'h0);
    chk(pb_oe, 32'h00);
    chk(pc_out, 32'h00);
    chk(pc_oe, 32'h78);
    chk(proc_flags, 32'h0);
    chk({prog_counter, pe_oe, bus_oe}, 32'h0);
    hold_req = 1'b0;
    sys_rst = 1'b0;
    nwait(1);
    chk({pe_oe, bus_oe}, 32'h3);
  endtask
  task automatic irq_test();
    sr_write(SR_MK, 8'h00);
    pulse(6);
    ext_select_edge_irq = 1'b1;
    nwait(5);
    chk(irq_req, 32'h0);
    ext_select_edge_irq = 1'b0;
    nwait(5);
    chk_vec(8'h20);
    ext_level_irq = 1'b1;
    pulse(4);
    nwait(2);
    chk_vec(8'h60);
    pulse(5);
    nwait(2);
    chk_vec(8'h04);
    ext_level_irq = 1'b0;
    nwait(3);
    pulse(5);
    nwait(2);
    chk_vec(8'h20);
    pulse(5);
    nwait(2);
    chk(irq_req, 32'h0);
    sr_write(SR_MK, 8'h20);
    ext_rise_irq = 1'b1;
    ext_select_edge_irq = 1'b1;
    nwait(5);
    chk_vec(8'h10);
    pulse(5);
    nwait(2);
    chk_vec(8'h20);
    ext_rise_irq = 1'b0;
    ext_select_edge_irq = 1'b0;
    pulse(5);
    nwait(2);
    chk(irq_req, 32'h0);
  endtask
  task automatic timer_test();
    int k;
    sr_write(SR_TM0, 8'h02);
    sr_write(SR_TM1, 8'h00);
    pulse(0);
    nwait(1);
    chk(timer_count, 32'h002);
    nwait(1);
    chk(timer_out_pin, 32'h1);
    nwait(796);
    chk(timer_count, 32'h002);
    nwait(3);
    chk(timer_count, 32'h001);
    for (k = 801; k < 3000 && timer_out_pin; k++) @(negedge clk);
    chk(k inside {[2400:2403]}, 32'h1);
    chk(timer_count, 32'h002);
    nwait(1);
    chk_vec(8'h08);
    pulse(5);
    sr_write(SR_MK, 8'h08);
    nwait(2500);
    chk({irq_req, timer_out_pin}, 32'h0);
    pulse(0);
    nwait(1);
    chk(timer_out_pin, 32'h1);
  endtask
  task automatic serial_test();
    sr_write(SR_MC, 8'hfb);
    sr_write(SR_S, 8'h3c);
    chk(serial_ack, 32'h1);
    mtsir_ser_dev_inst.xfer(8'ha5, 80, rx);
    nwait(4);
    chk(rx, 32'h3c);
    chk(ser_data, 32'ha5);
    chk(serial_ack, 32'h0);
    chk_vec(8'h40);
    pulse(5);
    mtsir_ser_dev_inst.xfer(8'h5a, 400, rx);
    nwait(4);
    chk(ser_data, 32'ha5);
    pulse(7);
    chk(serial_ack, 32'h1);
    serial_clk_int = 1'b1;
    mtsir_ser_dev_inst.select_with(1'b0, 1'b1);
    nwait(4);
    chk({sck_oe, sck_out}, 32'h3);
    nwait(1610);
    chk({serial_ack, ser_data}, 32'h0ff);
    chk_vec(8'h40);
    mtsir_ser_dev_inst.select_with(1'b1, 1'b0);
    serial_clk_int = 1'b0;
    pulse(5);
  endtask
  task automatic porte_test();
    pulse(3);
    nwait(2);
    chk(pe_out, 32'h1234);
    pulse(2);
    sr_write(SR_PEN, 8'h0a);
    nwait(2);
    chk(pe_out, 32'haeef);
    pulse(1);
    nwait(2);
    chk(pe_out, 32'hbeef);
  endtask
  task automatic rerun_reset_test();
    pulse(10);
    pulse(11);
    pulse(8);
    hold_req = 1'b1;
    nwait(2);
    chk({halted, proc_flags}, 32'h6);
    chk(prog_counter, 32'h1234);
    do_reset(801);
  endtask
  initial begin
    ins = 12'h000;
    sr_wr = 1'b0;
    sr_sel = 4'h0;
    sr_wdata = 8'h00;
    reg_b = 8'h12;
    reg_c = 8'h34;
    cpu_addr = 16'hbeef;
    serial_clk_int = 1'b0;
    ext_level_irq = 1'b0;
    ext_select_edge_irq = 1'b0;
    hold_req = 1'b0;
    ext_rise_irq = 1'b0;
    flags_wdata = 2'h2;
    pc_wdata = 16'h1234;
    do_reset(4);
    irq_test();
    timer_test();
    serial_test();
    porte_test();
    rerun_reset_test();
    report_and_stop();
  end
endmodule
`default_nettype wire
